// ===== hdl/pmc_top.sv
/*
  Power-mode and clock control: operating states, regulator handshake,
  clock enables derived from the PLL output, and the clock output pin.
  Assumes pclk stands for the PLL output and the block sits on APB.
*/
`timescale 1ns/1ns
`include "pmc_map.svh"

module pmc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic input_clk_pin,
  input wire logic reset_pin_n,
  input wire logic [1:0] wake_src_in,
  input wire logic power_good_in_n,
  output logic regulator_wake_out,
  output logic pin_hiz,
  output logic core_supply_on,
  output logic async_access_block,
  output logic sys_reset_out,
  output logic pll_enable,
  output logic pll_bypass,
  output logic [5:0] pll_multiplier,
  output logic core_clk,
  output logic sys_clk_en,
  output logic external_clock_out,
  output logic external_clock_oe
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [2:0] pmc_core_max(input logic [1:0] core_clk_divisor_field);
    case (core_clk_divisor_field)
      2'h0: pmc_core_max = 3'h0;
      2'h1: pmc_core_max = 3'h1;
      2'h2: pmc_core_max = 3'h3;
      default: pmc_core_max = 3'h7;
    endcase
  endfunction : pmc_core_max

  function automatic logic [3:0] pmc_sys_max(input logic [3:0] ssel);
    pmc_sys_max = ssel - 4'h1;
  endfunction : pmc_sys_max

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic clk_in_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 5'h06;
      sync_b <= 5'h06;
      clk_in_prev <= 1'b0;
    end else begin
      sync_a <= {wake_src_in, power_good_in_n, reset_pin_n, input_clk_pin};
      sync_b <= sync_a;
      clk_in_prev <= sync_b[0];
    end
  end

  wire buffered_input_clk = sync_b[0];
  wire reset_pin_low = !sync_b[1];
  wire power_good = !sync_b[2];
  wire [1:0] wake_src = sync_b[4:3];
  wire in_rise = buffered_input_clk && !clk_in_prev;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  pmc_pkg::pmc_state_type state;
  pmc_pkg::pmc_state_type next_state;
  pmc_pkg::pmc_div_type cur_div;
  pmc_pkg::pmc_div_type pend_div;
  pmc_pkg::pmc_req_type req;
  logic [5:0] mult;
  logic bypass;
  logic hib_n;
  logic [1:0] wake_en;
  logic system_clock_forward_en;
  logic system_clock_forward_buf;
  logic [3:0] sys_cnt;
  logic [2:0] core_cnt;
  logic [4:0] boot_cnt;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  wire take = psel && penable && pready;
  wire access_first = psel && penable && !pready;
  wire read_first = access_first && !req.write;
  wire wr = take && req.write;
  wire sel_ctl = req.addr == `PMC_OFS_PLL_CTL;
  wire sel_div = req.addr == `PMC_OFS_PLL_DIV;
  wire sel_vr = req.addr == `PMC_OFS_REGULATOR_CONTROL_REG;
  wire sel_mg = req.addr == `PMC_OFS_MEM_GCTL;
  wire sel_st = req.addr == `PMC_OFS_STATUS;
  wire mapped = sel_ctl || sel_div || sel_vr || sel_mg || sel_st;
  wire wr_ctl = wr && sel_ctl;
  wire wr_div = wr && sel_div;
  wire wr_vr = wr && sel_vr;
  wire wr_mg = wr && sel_mg;
  wire [3:0] new_ssel = req.wdata[`PMC_DIV_SSEL_MSB:`PMC_DIV_SSEL_LSB];
  wire [1:0] new_core_clk_divisor_field = req.wdata[`PMC_DIV_CORE_CLK_DIVISOR_FIELD_MSB:`PMC_DIV_CORE_CLK_DIVISOR_FIELD_LSB];

  wire [31:0] rd_ctl = {23'h0, bypass, 2'h0, mult};
  wire [31:0] rd_div = {26'h0, pend_div.core_clk_divisor_field, pend_div.ssel};
  wire [31:0] rd_vr = {29'h0, wake_en, hib_n};
  wire [31:0] rd_mg = {30'h0, system_clock_forward_buf, system_clock_forward_en};
  wire [31:0] rd_st = {22'h0, power_good, cur_div.core_clk_divisor_field, cur_div.ssel, state};
  wire [31:0] rd_mux = sel_ctl ? rd_ctl :
                       sel_div ? rd_div :
                       sel_vr ? rd_vr :
                       sel_mg ? rd_mg :
                       sel_st ? rd_st : 32'h0;

  // ----------------------------------------
  // APB answer, one wait cycle per access
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access_first;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access_first && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else begin
      prdata <= read_first ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------
  // State decode
  // ----------------------------------------
  wire in_boot = state == pmc_pkg::PMC_BOOT;
  wire in_hib = state == pmc_pkg::PMC_HIB;
  wire in_deep = state == pmc_pkg::PMC_DEEP;
  wire running = state == pmc_pkg::PMC_FULL_ON || state == pmc_pkg::PMC_ACTIVE;
  wire wake_evt = reset_pin_low || |(wake_src & wake_en); // see [RQ8]
  wire sys_edge = sys_cnt == 4'h0;
  wire core_edge = core_cnt == 3'h0;

  // ----------------------------------------
  // Register file, regulator control kept over hibernate
  // ----------------------------------------
  wire vr_write = wr_vr && running;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult <= `PMC_MULT_RST; // see [RQ12]
      bypass <= 1'b0; // see [RQ19]
    end else if (in_boot) begin
      mult <= `PMC_MULT_RST; // see [RQ10]
      bypass <= 1'b0;
    end else if (wr_ctl) begin
      mult <= req.wdata[`PMC_CTL_MULT_MSB:`PMC_CTL_MULT_LSB]; // see [RQ12]
      bypass <= req.wdata[`PMC_CTL_BYPASS]; // see [RQ20]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clock_forward_en <= 1'b1; // see [RQ18]
      system_clock_forward_buf <= 1'b0;
    end else if (in_boot) begin
      system_clock_forward_en <= 1'b1;
      system_clock_forward_buf <= 1'b0;
    end else if (wr_mg) begin
      system_clock_forward_en <= req.wdata[`PMC_MG_SYSTEM_CLOCK_FORWARD_EN]; // see [RQ18]
      system_clock_forward_buf <= req.wdata[`PMC_MG_SYSTEM_CLOCK_FORWARD_BUF]; // see [RQ17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_div <= '{core_clk_divisor_field: `PMC_CORE_CLK_DIVISOR_FIELD_RST, ssel: `PMC_SSEL_RST};
    end else if (in_boot) begin
      pend_div <= '{core_clk_divisor_field: `PMC_CORE_CLK_DIVISOR_FIELD_RST, ssel: `PMC_SSEL_RST};
    end else if (wr_div) begin
      pend_div.core_clk_divisor_field <= new_core_clk_divisor_field; // see [RQ15]
      if (new_ssel != 4'h0) begin
        pend_div.ssel <= new_ssel; // see [RQ22]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hib_n <= 1'b1;
    end else if (in_hib && wake_evt) begin
      hib_n <= 1'b1; // see [RQ10]
    end else if (vr_write) begin
      hib_n <= req.wdata[`PMC_VR_HIB_N]; // see [RQ5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en <= `PMC_WAKE_EN_RST;
    end else if (vr_write) begin
      wake_en <= req.wdata[`PMC_VR_WAKE_MSB:`PMC_VR_WAKE_LSB]; // see [RQ8]
    end
  end

  // ----------------------------------------
  // Operating state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      pmc_pkg::PMC_FULL_ON, pmc_pkg::PMC_ACTIVE: begin
        if (reset_pin_low) begin
          next_state = pmc_pkg::PMC_BOOT;
        end else if (!hib_n) begin
          next_state = pmc_pkg::PMC_HIB; // see [RQ4]
        end else if (wr_ctl && req.wdata[`PMC_CTL_DEEP_REQ]) begin
          next_state = pmc_pkg::PMC_DEEP; // see [RQ1]
        end else begin
          next_state = bypass ? pmc_pkg::PMC_ACTIVE : pmc_pkg::PMC_FULL_ON; // see [RQ20]
        end
      end
      pmc_pkg::PMC_DEEP: begin
        if (reset_pin_low) begin
          next_state = pmc_pkg::PMC_BOOT; // see [RQ3]
        end
      end
      pmc_pkg::PMC_HIB: begin
        if (wake_evt) begin
          next_state = pmc_pkg::PMC_PG_WAIT; // see [RQ7]
        end
      end
      pmc_pkg::PMC_PG_WAIT: begin
        if (power_good) begin
          next_state = pmc_pkg::PMC_BOOT; // see [RQ11]
        end
      end
      pmc_pkg::PMC_BOOT: begin
        if (boot_cnt == 5'h0 && !reset_pin_low) begin
          next_state = pmc_pkg::PMC_FULL_ON; // see [RQ3]
        end
      end
      default: begin
        next_state = pmc_pkg::PMC_BOOT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pmc_pkg::PMC_FULL_ON; // see [RQ19]
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt <= `PMC_BOOT_CYCLES;
    end else if (!in_boot || reset_pin_low) begin
      boot_cnt <= `PMC_BOOT_CYCLES;
    end else if (boot_cnt != 5'h0) begin
      boot_cnt <= boot_cnt - 5'h1;
    end
  end

  // ----------------------------------------
  // Dividers, new divisors taken at a boundary
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_div <= '{core_clk_divisor_field: `PMC_CORE_CLK_DIVISOR_FIELD_RST, ssel: `PMC_SSEL_RST};
      sys_cnt <= 4'h0;
      core_cnt <= 3'h0;
    end else if (!running) begin
      cur_div <= pend_div;
      sys_cnt <= 4'h0;
      core_cnt <= 3'h0;
    end else begin
      if (sys_edge) begin
        cur_div.ssel <= pend_div.ssel; // see [RQ21]
        sys_cnt <= pmc_sys_max(pend_div.ssel); // see [RQ13] [RQ14]
      end else begin
        sys_cnt <= sys_cnt - 4'h1;
      end
      if (core_edge) begin
        cur_div.core_clk_divisor_field <= pend_div.core_clk_divisor_field; // see [RQ21]
        core_cnt <= pmc_core_max(pend_div.core_clk_divisor_field); // see [RQ15]
      end else begin
        core_cnt <= core_cnt - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Clock enables and clock output pin
  // ----------------------------------------
  wire full_on = state == pmc_pkg::PMC_FULL_ON;
  wire active = state == pmc_pkg::PMC_ACTIVE;
  wire next_sys = (full_on && sys_edge) || (active && in_rise); // see [RQ16] [RQ20]
  wire next_core = (full_on && core_edge) || (active && in_rise);
  wire next_system_clock_forward = system_clock_forward_buf ? buffered_input_clk : next_sys; // see [RQ17]
  wire pin_on = system_clock_forward_en && !in_hib;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_en <= 1'b0;
      core_clk <= 1'b0;
    end else begin
      sys_clk_en <= next_sys; // see [RQ1]
      core_clk <= next_core; // see [RQ1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_clock_out <= 1'b0;
      external_clock_oe <= 1'b0;
    end else begin
      external_clock_out <= pin_on && next_system_clock_forward; // see [RQ18]
      external_clock_oe <= pin_on; // see [RQ6]
    end
  end

  // ----------------------------------------
  // Power and PLL outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_wake_out <= 1'b1;
      core_supply_on <= 1'b1;
    end else begin
      regulator_wake_out <= !in_hib; // see [RQ5] [RQ9]
      core_supply_on <= !in_hib; // see [RQ4]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_hiz <= 1'b0;
      async_access_block <= 1'b0;
    end else begin
      pin_hiz <= in_hib; // see [RQ6]
      async_access_block <= in_deep || in_hib; // see [RQ2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_out <= 1'b1;
    end else begin
      sys_reset_out <= in_boot || state == pmc_pkg::PMC_PG_WAIT; // see [RQ7]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_enable <= 1'b1;
      pll_bypass <= 1'b0;
      pll_multiplier <= `PMC_MULT_RST;
    end else begin
      pll_enable <= running; // see [RQ12]
      pll_bypass <= active; // see [RQ20]
      pll_multiplier <= mult;
    end
  end

endmodule : pmc_top

// ===== hdl/pmc_map.svh
/*
  Offsets, field positions, reset values and counts of the power-mode and
  clock control block.
  Assumes inclusion by bare name from the design files of this block.
*/
// Functional notes
// [RQ1] Deep sleep stops both core clock and system clock enables.
// [RQ2] Deep sleep blocks clockless peripherals from internal and external memory.
// [RQ3] Deep sleep ends only on reset pin, then device returns to full-on.
// [RQ4] Hibernate removes clocks and core supply, supply taken to zero volts.
// [RQ5] Writing zero to hibernate control bit drives regulator wake output low.
// [RQ6] During hibernate all external pins are released to high impedance.
// [RQ7] Every hibernate wakeup, reset pin included, starts the hardware reset sequence.
// [RQ8] Each wakeup source acts only when its enable in regulator control is set; the code lets the reset pin wake without an enable.
// [RQ9] Regulator wake output is active high and rises on a wakeup event.
// [RQ10] Regulator control survives hibernate; all other registers return to defaults.
// [RQ11] After hibernate, start waits for power-good input to show supply ready.
// [RQ12] Clocks derive from input clock through PLL; multiplier resets to six.
// [RQ13] Divider writes change clocks on the fly, no relock wait.
// [RQ14] Four-bit system divisor sets PLL to system clock ratio, 1 to 15.
// [RQ15] Core divisor codes 00,01,10,11 divide by 1,2,4,8.
// [RQ16] All peripherals run from the system clock enable, never the core one.
// [RQ17] Clock output pin carries system clock or buffered input clock.
// [RQ18] Clock output active after reset; disabled via memory global control.
// [RQ19] After power-up the device is in full-on, PLL enabled, not bypassed.
// [RQ20] Active mode bypasses PLL; core and system clocks follow input clock.
// [RQ21] Divisor changes apply on a divided-clock boundary, no short pulse.
// [RQ22] System divisor code zero is illegal and keeps the previous divisor.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMC_OFS_PLL_CTL 12'h000
`define PMC_OFS_PLL_DIV 12'h004
`define PMC_OFS_REGULATOR_CONTROL_REG 12'h008
`define PMC_OFS_MEM_GCTL 12'h00C
`define PMC_OFS_STATUS 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMC_CTL_MULT_LSB 0
`define PMC_CTL_MULT_MSB 5
`define PMC_CTL_BYPASS 8
`define PMC_CTL_DEEP_REQ 12
`define PMC_DIV_SSEL_LSB 0
`define PMC_DIV_SSEL_MSB 3
`define PMC_DIV_CORE_CLK_DIVISOR_FIELD_LSB 4
`define PMC_DIV_CORE_CLK_DIVISOR_FIELD_MSB 5
`define PMC_VR_HIB_N 0
`define PMC_VR_WAKE_LSB 1
`define PMC_VR_WAKE_MSB 2
`define PMC_MG_SYSTEM_CLOCK_FORWARD_EN 0
`define PMC_MG_SYSTEM_CLOCK_FORWARD_BUF 1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define PMC_MULT_RST 6'h06
`define PMC_SSEL_RST 4'h5
`define PMC_CORE_CLK_DIVISOR_FIELD_RST 2'h0
`define PMC_WAKE_EN_RST 2'h0
`define PMC_BOOT_CYCLES 5'h10

`endif

// ===== hdl/pmc_pkg.sv
/*
  Types of the power-mode and clock control block.
  Assumes the offsets and counts come from pmc_map.svh.
*/
package pmc_pkg;

  // ----------------------------------------
  // Operating states
  // ----------------------------------------
  typedef enum logic [2:0] {
    PMC_FULL_ON = 3'h0,
    PMC_DEEP = 3'h1,
    PMC_HIB = 3'h3,
    PMC_PG_WAIT = 3'h2,
    PMC_BOOT = 3'h6,
    PMC_ACTIVE = 3'h4
  } pmc_state_type;

  // ----------------------------------------
  // Divider settings
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] core_clk_divisor_field;
    logic [3:0] ssel;
  } pmc_div_type;

  // ----------------------------------------
  // Bus request, taken unregistered from the APB inputs
  // ----------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } pmc_req_type;

endpackage : pmc_pkg

// ===== test/pmc_chk.sv
/*
  Checker of the power-mode and clock control block.
  Assumes the bind at the foot attaches it to pmc_top.
*/
`timescale 1ns/1ns
module pmc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_n,
  input wire logic power_good_in_n,
  input wire logic regulator_wake_out,
  input wire logic pin_hiz,
  input wire logic core_supply_on,
  input wire logic async_access_block,
  input wire logic sys_reset_out,
  input wire logic pll_enable,
  input wire logic pll_bypass,
  input wire logic [5:0] pll_multiplier,
  input wire logic core_clk,
  input wire logic sys_clk_en,
  input wire logic external_clock_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Properties
  // ----
  a_sleep_no_pulse: assert property (async_access_block |-> !sys_clk_en && !core_clk)
    else $error("clock pulse while asleep");
  a_hib_released: assert property (pin_hiz |-> !external_clock_oe && !core_supply_on
    && !regulator_wake_out) else $error("pins or supply active in hibernate");
  a_wake_boots: assert property ($rose(regulator_wake_out) |-> sys_reset_out)
    else $error("wake without reset sequence");
  a_pg_holds: assert property (power_good_in_n [*4] ##0 sys_reset_out |=> sys_reset_out)
    else $error("start without power good");
  a_mult_default: assert property ($rose(presetn) |-> pll_multiplier == 6'h06)
    else $error("multiplier reset value wrong");
  a_system_clock_forward_on: assert property ($rose(presetn) |=> external_clock_oe)
    else $error("clock output off after reset");
  a_full_pll: assert property (!sys_reset_out && !async_access_block |-> pll_enable)
    else $error("pll off while running");
  a_bypass_run: assert property (pll_bypass |-> pll_enable && !async_access_block)
    else $error("bypass outside active mode");
  a_deep_holds: assert property (reset_pin_n [*5] ##0 (async_access_block && !pin_hiz)
    |=> async_access_block) else $error("deep sleep left without reset pin");
  c_deep: cover property (async_access_block && !pin_hiz);
  c_hib: cover property (pin_hiz);
  c_active: cover property (pll_bypass && sys_clk_en);
endmodule : pmc_chk

bind pmc_top pmc_chk u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .reset_pin_n(reset_pin_n),
  .power_good_in_n(power_good_in_n),
  .regulator_wake_out(regulator_wake_out),
  .pin_hiz(pin_hiz),
  .core_supply_on(core_supply_on),
  .async_access_block(async_access_block),
  .sys_reset_out(sys_reset_out),
  .pll_enable(pll_enable),
  .pll_bypass(pll_bypass),
  .pll_multiplier(pll_multiplier),
  .core_clk(core_clk),
  .sys_clk_en(sys_clk_en),
  .external_clock_oe(external_clock_oe)
);

// ===== test/pmc_regulator_model.sv
/*
  Behavioural external core regulator with a power-good output.
  Assumes its wake input comes from the regulator wake output.
*/
`timescale 1ns/1ns
module pmc_regulator_model #(
  parameter int PG_DELAY = 10
) (
  input wire logic pclk,
  input wire logic wake_in,
  output logic power_good_n
);
  int ramp = 0;
  initial power_good_n = 1'b1;
  // ----
  // Supply ramp
  // ----
  always @(posedge pclk) begin
    if (!wake_in) begin
      ramp <= 0;
      power_good_n <= 1'b1;
    end else if (ramp < PG_DELAY) begin
      ramp <= ramp + 1;
    end else begin
      power_good_n <= 1'b0;
    end
  end
endmodule : pmc_regulator_model

// ===== test/tb_pmc_top.sv
/*
  Testbench of the power-mode and clock control block.
  Assumes pmc_top, its checker and the regulator model are compiled first.
*/
`timescale 1ns/1ns
module tb_pmc_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic input_clk_pin = 1'b0;
  logic reset_pin_n = 1'b1;
  logic [1:0] wake_src_in = 2'h0;
  logic [1:0] icnt = 2'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, power_good_in_n, regulator_wake_out, pin_hiz;
  logic core_supply_on, async_access_block, sys_reset_out, pll_enable, pll_bypass;
  logic core_clk, sys_clk_en, external_clock_out, external_clock_oe;
  logic [5:0] pll_multiplier;
  int n_errors = 0;
  int compares = 0;
  logic [31:0] ns, nc, ne;

  initial begin
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    icnt <= icnt + 2'h1;
    if (icnt == 2'h3) input_clk_pin <= ~input_clk_pin;
  end

  pmc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_clk_pin(input_clk_pin), .reset_pin_n(reset_pin_n),
    .wake_src_in(wake_src_in), .power_good_in_n(power_good_in_n),
    .regulator_wake_out(regulator_wake_out), .pin_hiz(pin_hiz),
    .core_supply_on(core_supply_on), .async_access_block(async_access_block),
    .sys_reset_out(sys_reset_out), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
    .pll_multiplier(pll_multiplier), .core_clk(core_clk), .sys_clk_en(sys_clk_en),
    .external_clock_out(external_clock_out), .external_clock_oe(external_clock_oe));
  pmc_regulator_model u_reg (.pclk(pclk), .wake_in(regulator_wake_out),
    .power_good_n(power_good_in_n));

  // ----
  // Tasks
  // ----
  task close_out;
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task fail_out;
    chk(32'h0, 32'h1);
    close_out();
  endtask : fail_out
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) fail_out();
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task wait_on(input logic sel, input logic v);
    int n;
    n = 0;
    while ((sel ? regulator_wake_out : sys_reset_out) !== v) begin
      n++;
      if (n > 200) fail_out();
      @(posedge pclk);
    end
  endtask : wait_on
  task count;
    ns = 0;
    nc = 0;
    ne = 0;
    repeat (64) begin
      @(posedge pclk);
      ns += sys_clk_en;
      nc += core_clk;
      ne += external_clock_out;
    end
  endtask : count

  // ----
  // Sequence
  // ----
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 32'h6);
    rd(12'h004, 32'h5);
    rd(12'h008, 32'h1);
    rd(12'h00C, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk(q & 32'h1FF, 32'h28);
    apb(1'b0, 12'h020, 32'h0);
    chk({q[30:0], err}, 32'h1);
    apb(1'b1, 12'h004, 32'h10);
    rd(12'h004, 32'h15);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h004, {26'h0, c[1:0], 4'h4});
      repeat (20) @(posedge pclk);
      count();
      chk(ns, 32'h10);
      chk(nc, 32'h40 >> c);
      apb(1'b0, 12'h010, 32'h0);
      chk({26'h0, q[8:3]}, {26'h0, c[1:0], 4'h4});
    end
    apb(1'b1, 12'h000, 32'h10B);
    apb(1'b1, 12'h00C, 32'h3);
    rd(12'h00C, 32'h3);
    repeat (20) @(posedge pclk);
    count();
    chk(ns, 32'h8);
    chk(nc, 32'h8);
    chk(ne, 32'h20);
    chk({24'h0, pll_enable, pll_bypass, pll_multiplier}, 32'hCB);
    apb(1'b1, 12'h00C, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, external_clock_oe}, 32'h0);
    apb(1'b1, 12'h008, 32'h7);
    rd(12'h008, 32'h7);
    apb(1'b1, 12'h000, 32'h1006);
    wake_src_in <= 2'h3;
    repeat (3) @(posedge pclk);
    count();
    chk(ns + nc, 32'h0);
    chk({31'h0, async_access_block}, 32'h1);
    wake_src_in <= 2'h0;
    reset_pin_n <= 1'b0;
    wait_on(1'b0, 1'b1);
    reset_pin_n <= 1'b1;
    wait_on(1'b0, 1'b0);
    rd(12'h010, 32'h228);
    apb(1'b1, 12'h004, 32'h17);
    apb(1'b1, 12'h008, 32'h2);
    repeat (3) @(posedge pclk);
    chk({regulator_wake_out, pin_hiz, core_supply_on, external_clock_oe}, 32'h4);
    wake_src_in <= 2'h2;
    repeat (8) @(posedge pclk);
    chk({31'h0, pin_hiz}, 32'h1);
    wake_src_in <= 2'h1;
    wait_on(1'b1, 1'b1);
    repeat (5) @(posedge pclk);
    chk({31'h0, sys_reset_out}, 32'h1);
    wake_src_in <= 2'h0;
    wait_on(1'b0, 1'b0);
    rd(12'h008, 32'h3);
    rd(12'h004, 32'h5);
    close_out();
  end
endmodule : tb_pmc_top
